// *** irc_pkg.sv ***
// Package with timing constants, code layouts and state encodings for the IR codec.
package irc_pkg;

  // ****************************************
  // Timebase
  // ****************************************
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TICK_US      = 10;
  localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned CARRIER_HZ   = 38_000;
  localparam int unsigned CAR_HALF_DEF = CLK_HZ / (2 * CARRIER_HZ);
  localparam int          LEN_W        = 12;
  localparam int          CNT_W        = 6;
  localparam int          TOL_SHIFT    = 2;

  // ****************************************
  // Pulse times in microseconds and in ticks
  // ****************************************
  localparam int unsigned A_LEAD_MARK_US  = 9000;
  localparam int unsigned A_LEAD_SPACE_US = 4500;
  localparam int unsigned A_RPT_SPACE_US  = 2250;
  localparam int unsigned A_BIT_MARK_US   = 562;
  localparam int unsigned A_ONE_SPACE_US  = 1687;
  localparam int unsigned B_LEAD_MARK_US  = 2400;
  localparam int unsigned B_UNIT_US       = 600;
  localparam int unsigned B_ONE_MARK_US   = 1200;
  localparam int unsigned RX_TMO_US       = 12000;
  localparam int unsigned TX_FRAME_US     = 25000;

  localparam logic [LEN_W-1:0] A_LEAD_MARK_T  = LEN_W'(A_LEAD_MARK_US / TICK_US);
  localparam logic [LEN_W-1:0] A_LEAD_SPACE_T = LEN_W'(A_LEAD_SPACE_US / TICK_US);
  localparam logic [LEN_W-1:0] A_RPT_SPACE_T  = LEN_W'(A_RPT_SPACE_US / TICK_US);
  localparam logic [LEN_W-1:0] A_BIT_MARK_T   = LEN_W'(A_BIT_MARK_US / TICK_US);
  localparam logic [LEN_W-1:0] A_ONE_SPACE_T  = LEN_W'(A_ONE_SPACE_US / TICK_US);
  localparam logic [LEN_W-1:0] B_LEAD_MARK_T  = LEN_W'(B_LEAD_MARK_US / TICK_US);
  localparam logic [LEN_W-1:0] B_UNIT_T       = LEN_W'(B_UNIT_US / TICK_US);
  localparam logic [LEN_W-1:0] B_ONE_MARK_T   = LEN_W'(B_ONE_MARK_US / TICK_US);
  localparam logic [LEN_W-1:0] RX_TMO_T       = LEN_W'(RX_TMO_US / TICK_US);
  localparam logic [LEN_W-1:0] TX_FRAME_T     = LEN_W'(TX_FRAME_US / TICK_US);
  localparam logic [LEN_W-1:0] LEN_MAX        = {LEN_W{1'b1}};

  // ****************************************
  // Frame layouts
  // ****************************************
  localparam int               CODE_W     = 8;
  localparam int               B_KEY_W    = 7;
  localparam int               B_DEV_W    = 5;
  localparam int               A_DEV_LSB  = 24;
  localparam int               A_KEY_LSB  = 8;
  localparam int               A_INV_LSB  = 0;
  localparam int               B_KEY_LSB  = 20;
  localparam int               B_DEV_LSB  = 27;
  localparam logic [CNT_W-1:0] A_LAST_BIT = 6'h1f;
  localparam logic [CNT_W-1:0] B_LAST_BIT = 6'h0b;

  typedef enum logic [3:0] {
    IRC_RX_IDLE   = 4'h1,
    IRC_RX_A_HDR  = 4'h2,
    IRC_RX_A_BITS = 4'h4,
    IRC_RX_B_BITS = 4'h8
  } irc_rx_state_t;

  typedef enum logic [4:0] {
    IRC_TX_IDLE  = 5'h01,
    IRC_TX_START = 5'h02,
    IRC_TX_SPACE = 5'h04,
    IRC_TX_MARK  = 5'h08,
    IRC_TX_TAIL  = 5'h10
  } irc_tx_state_t;

  // A pulse matches when it lies within a quarter of its nominal length.
  function automatic logic irc_near(input logic [LEN_W-1:0] len, input logic [LEN_W-1:0] nom);
    irc_near = (len >= nom - (nom >> TOL_SHIFT)) && (len <= nom + (nom >> TOL_SHIFT));
  endfunction

endpackage

// *** irc_ir_codec.sv ***
// Infrared remote codec: two-protocol background receiver and 12-bit frame transmitter.
`timescale 1ns/1ps
// What this block does
// - Decodes both protocols without any mode select.
// - Runs in background; valid frame updates codes.
// - Event on new key and on each repeat after a first protocol key.
// - First protocol codes held bit-reversed.
// - Stop request halts decoding, updates and events.
// - Send request emits one 12-bit frame.
// - Transmit pin low idle and in spaces; busy high while emitting.
// - Marks carry 38 kHz; transmission lasts 25 ms.
module irc_ir_codec #(
  parameter logic [irc_pkg::LEN_W-1:0] TICK_CYCLES = irc_pkg::LEN_W'(irc_pkg::TICK_CYC_DEF),
  parameter logic [irc_pkg::LEN_W-1:0] CAR_HALF    = irc_pkg::LEN_W'(irc_pkg::CAR_HALF_DEF)
) (
  input  wire logic                               clk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               ir_rx_n_i,
  input  wire logic                               decoder_start_request_i,
  input  wire logic                               decoder_stop_request_i,
  input  wire logic                               transmit_request_i,
  input  wire logic [irc_pkg::B_DEV_W-1:0]        tx_dev_i,
  input  wire logic [irc_pkg::B_KEY_W-1:0]        tx_key_i,
  output logic                                    decoder_active_o,
  output logic      [irc_pkg::CODE_W-1:0]         dev_code_o,
  output logic      [irc_pkg::CODE_W-1:0]         key_code_o,
  output logic                                    key_event_o,
  output logic                                    ir_tx_o,
  output logic                                    tx_busy_o
);
  import irc_pkg::*;
  // ****************************************
  // Timebase and input synchroniser
  // ****************************************
  logic [LEN_W-1:0] tick_cnt, next_tick_cnt;
  logic             tick;
  logic             rx_s1, rx_s2, rx_s3;
  logic             mark_end, space_end;
  always_comb begin
    tick          = (tick_cnt == TICK_CYCLES - 1'b1);
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
    end else begin
      tick_cnt <= next_tick_cnt;
      rx_s1    <= ir_rx_n_i;
      rx_s2    <= rx_s1;
      rx_s3    <= rx_s2;
    end
  end

  // The receiver module drives low while light is seen, so a rising edge ends a mark.
  assign mark_end  = rx_s2 & ~rx_s3;
  assign space_end = ~rx_s2 & rx_s3;
  // ****************************************
  // Receiver
  // ****************************************
  irc_rx_state_t     rx_state, next_rx_state;
  logic [LEN_W-1:0]  rx_len, next_rx_len;
  logic [CNT_W-1:0]  rx_cnt, next_rx_cnt;
  logic [31:0]       rx_sr, next_rx_sr;
  logic              have_key, next_have_key;
  logic              next_active, next_event;
  logic [CODE_W-1:0] next_dev, next_key;
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_sr    = rx_sr;
    next_have_key = have_key;
    next_dev      = dev_code_o;
    next_key      = key_code_o;
    next_event    = 1'b0;
    next_rx_len   = (mark_end || space_end) ? '0 : (tick && rx_len != LEN_MAX) ? rx_len + 1'b1 : rx_len;
    next_active = (decoder_active_o | decoder_start_request_i) & ~decoder_stop_request_i;
    case (rx_state)
      IRC_RX_IDLE: begin
        if (mark_end) begin
          next_rx_cnt = '0;
          if (irc_near(rx_len, A_LEAD_MARK_T)) begin
            next_rx_state = IRC_RX_A_HDR;
          end else if (irc_near(rx_len, B_LEAD_MARK_T)) begin
            next_rx_state = IRC_RX_B_BITS;
          end
        end
      end
      IRC_RX_A_HDR: begin
        if (space_end) begin
          next_rx_state = IRC_RX_IDLE;
          if (irc_near(rx_len, A_LEAD_SPACE_T)) begin
            next_rx_state = IRC_RX_A_BITS;
          end else if (irc_near(rx_len, A_RPT_SPACE_T)) begin
            next_event = have_key;
          end
        end
      end
      IRC_RX_A_BITS: begin
        if (mark_end && !irc_near(rx_len, A_BIT_MARK_T)) begin
          next_rx_state = IRC_RX_IDLE;
        end else if (space_end) begin
          if (irc_near(rx_len, A_BIT_MARK_T) || irc_near(rx_len, A_ONE_SPACE_T)) begin
            // Shifting left leaves the first received bit on top, which reverses each byte.
            next_rx_sr  = {rx_sr[30:0], irc_near(rx_len, A_ONE_SPACE_T)};
            next_rx_cnt = rx_cnt + 1'b1;
            if (rx_cnt == A_LAST_BIT) begin
              next_rx_state = IRC_RX_IDLE;
              if (next_rx_sr[A_KEY_LSB +: CODE_W] == ~next_rx_sr[A_INV_LSB +: CODE_W]) begin
                next_dev      = next_rx_sr[A_DEV_LSB +: CODE_W];
                next_key      = next_rx_sr[A_KEY_LSB +: CODE_W];
                next_event    = 1'b1;
                next_have_key = 1'b1;
              end
            end
          end else begin
            next_rx_state = IRC_RX_IDLE;
          end
        end
      end
      IRC_RX_B_BITS: begin
        if (space_end && !irc_near(rx_len, B_UNIT_T)) begin
          next_rx_state = IRC_RX_IDLE;
        end else if (mark_end) begin
          if (irc_near(rx_len, B_UNIT_T) || irc_near(rx_len, B_ONE_MARK_T)) begin
            next_rx_sr  = {irc_near(rx_len, B_ONE_MARK_T), rx_sr[31:1]};
            next_rx_cnt = rx_cnt + 1'b1;
            if (rx_cnt == B_LAST_BIT) begin
              next_rx_state = IRC_RX_IDLE;
              next_dev      = CODE_W'(next_rx_sr[B_DEV_LSB +: B_DEV_W]);
              next_key      = CODE_W'(next_rx_sr[B_KEY_LSB +: B_KEY_W]);
              next_event    = 1'b1;
              next_have_key = 1'b0;
            end
          end else begin
            next_rx_state = IRC_RX_IDLE;
          end
        end
      end
      default: next_rx_state = IRC_RX_IDLE;
    endcase
    if (rx_state != IRC_RX_IDLE && rx_len >= RX_TMO_T) begin
      next_rx_state = IRC_RX_IDLE;
    end
    if (!next_active) begin
      next_rx_state = IRC_RX_IDLE;
      next_event    = 1'b0;
      next_have_key = 1'b0;
      next_dev      = dev_code_o;
      next_key      = key_code_o;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state         <= IRC_RX_IDLE;
      rx_len           <= '0;
      rx_cnt           <= '0;
      rx_sr            <= '0;
      have_key         <= 1'b0;
      decoder_active_o <= 1'b0;
      dev_code_o       <= '0;
      key_code_o       <= '0;
      key_event_o      <= 1'b0;
    end else begin
      rx_state         <= next_rx_state;
      rx_len           <= next_rx_len;
      rx_cnt           <= next_rx_cnt;
      rx_sr            <= next_rx_sr;
      have_key         <= next_have_key;
      decoder_active_o <= next_active;
      dev_code_o       <= next_dev;
      key_code_o       <= next_key;
      key_event_o      <= next_event;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  irc_tx_state_t                tx_state, next_tx_state;
  logic [LEN_W-1:0]             tx_len, next_tx_len, tx_total, next_tx_total;
  logic [LEN_W-1:0]             car_cnt, next_car_cnt;
  logic                         car_ph, next_car_ph;
  logic [B_DEV_W+B_KEY_W-1:0]   tx_pay, next_tx_pay;
  logic [CNT_W-1:0]             tx_bit, next_tx_bit;
  logic                         next_ir_tx;
  always_comb begin
    next_tx_state = tx_state;
    next_tx_pay   = tx_pay;
    next_tx_bit   = tx_bit;
    next_tx_len   = tick ? tx_len + 1'b1 : tx_len;
    next_tx_total = tick ? tx_total + 1'b1 : tx_total;
    next_car_cnt  = (car_cnt == CAR_HALF - 1'b1) ? '0 : car_cnt + 1'b1;
    next_car_ph   = (car_cnt == CAR_HALF - 1'b1) ? ~car_ph : car_ph;
    case (tx_state)
      IRC_TX_IDLE: begin
        // A request that arrives while a frame is going out is ignored.
        if (transmit_request_i) begin
          next_tx_state = IRC_TX_START;
          next_tx_pay   = {tx_dev_i, tx_key_i};
          next_tx_bit   = '0;
          next_tx_len   = '0;
          next_tx_total = '0;
          next_car_cnt  = '0;
          next_car_ph   = 1'b1;
        end
      end
      IRC_TX_START: begin
        if (tx_len == B_LEAD_MARK_T) begin
          next_tx_state = IRC_TX_SPACE;
          next_tx_len   = '0;
        end
      end
      IRC_TX_SPACE: begin
        if (tx_len == B_UNIT_T) begin
          next_tx_state = IRC_TX_MARK;
          next_tx_len   = '0;
        end
      end
      IRC_TX_MARK: begin
        if (tx_len == (tx_pay[tx_bit[3:0]] ? B_ONE_MARK_T : B_UNIT_T)) begin
          next_tx_len   = '0;
          next_tx_bit   = tx_bit + 1'b1;
          next_tx_state = (tx_bit == B_LAST_BIT) ? IRC_TX_TAIL : IRC_TX_SPACE;
        end
      end
      IRC_TX_TAIL: begin
        if (tx_total >= TX_FRAME_T) begin
          next_tx_state = IRC_TX_IDLE;
        end
      end
      default: next_tx_state = IRC_TX_IDLE;
    endcase
    next_ir_tx = (next_tx_state == IRC_TX_START || next_tx_state == IRC_TX_MARK) && next_car_ph;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state  <= IRC_TX_IDLE;
      tx_len    <= '0;
      tx_total  <= '0;
      car_cnt   <= '0;
      car_ph    <= 1'b0;
      tx_pay    <= '0;
      tx_bit    <= '0;
      ir_tx_o   <= 1'b0;
      tx_busy_o <= 1'b0;
    end else begin
      tx_state  <= next_tx_state;
      tx_len    <= next_tx_len;
      tx_total  <= next_tx_total;
      car_cnt   <= next_car_cnt;
      car_ph    <= next_car_ph;
      tx_pay    <= next_tx_pay;
      tx_bit    <= next_tx_bit;
      ir_tx_o   <= next_ir_tx;
      tx_busy_o <= next_tx_state != IRC_TX_IDLE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [19:0] busy_cyc;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_cyc <= '0;
    end else begin
      busy_cyc <= tx_busy_o ? busy_cyc + 1'b1 : '0;
    end
  end
  sequence s_b_lead;
    rx_state == IRC_RX_IDLE && mark_end && irc_near(rx_len, B_LEAD_MARK_T) && next_active;
  endsequence
  sequence s_tx_go; tx_state == IRC_TX_IDLE && transmit_request_i; endsequence
  a_b_lead_seen: assert property (s_b_lead |=> rx_state == IRC_RX_B_BITS) else $error("lead mark not taken");
  a_codes_event: assert property (!$stable(dev_code_o) || !$stable(key_code_o) |-> key_event_o)
    else $error("codes changed without event");
  a_event_active: assert property (key_event_o |-> $past(decoder_active_o) || decoder_active_o)
    else $error("event while stopped");
  a_b_code_range: assert property (key_event_o && $past(rx_state == IRC_RX_B_BITS) |-> dev_code_o[7:5] == 3'h0 && !key_code_o[7])
    else $error("second protocol code out of range");
  a_stop_quiet: assert property (decoder_stop_request_i |=> !decoder_active_o && !key_event_o && $stable(key_code_o))
    else $error("stop not honoured");
  a_tx_start: assert property (s_tx_go |=> tx_busy_o && ir_tx_o ##1 tx_state == IRC_TX_START)
    else $error("send not started");
  a_tx_idle_low: assert property (!tx_busy_o |-> !ir_tx_o) else $error("led on while idle");
  a_carrier_half: assert property ($rose(car_ph) |-> car_ph[*8]) else $error("carrier half period short");
  a_tx_length: assert property (tx_busy_o |-> busy_cyc <= 20'(TX_FRAME_T * TICK_CYCLES + TICK_CYCLES))
    else $error("transmission too long");
  a_rx_timeout: assert property (rx_state != IRC_RX_IDLE && rx_len >= RX_TMO_T |=> rx_state == IRC_RX_IDLE)
    else $error("stuck frame not dropped");
endmodule

// *** irc_ir_partner.sv ***
// Partner model: IR receiver module on the input pin and IR LED watcher on the output.
`timescale 1ns/1ps
module irc_ir_partner #(
  parameter int TICK = 4,
  parameter int CAR  = 9
) (
  input  wire logic clk_i,
  input  wire logic ir_tx_i,
  output logic      ir_rx_n_o
);
  int   widths[$];
  int   first_hi;
  int   hi_run;
  int   gap;
  int   start;
  int   cyc;
  logic led;

  initial begin
    ir_rx_n_o = 1'b1;
    first_hi = 0;
    hi_run = 0;
    gap = 0;
    start = 0;
    cyc = 0;
    led = 1'b0;
  end

  // ****************************************
  // Receiver module output
  // ****************************************
  // Demodulated level, low while light is seen; idles high like the pulled-up module output.
  task automatic level(input logic v, input int ticks);
    @(posedge clk_i);
    #1;
    ir_rx_n_o = v;
    repeat (ticks * TICK - 1) @(posedge clk_i);
  endtask

  // ****************************************
  // LED watcher
  // ****************************************
  // A mark ends only after one carrier period of darkness, so widths carry that stretch.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (ir_tx_i) begin
      gap <= 0;
      hi_run <= hi_run + 1;
    end else begin
      gap <= gap + 1;
      if (hi_run != 0 && first_hi == 0) first_hi <= hi_run;
      hi_run <= 0;
    end
    if (!led && ir_tx_i) begin
      led <= 1'b1;
      start <= cyc;
    end else if (led && !ir_tx_i && gap >= 2 * CAR) begin
      led <= 1'b0;
      widths.push_back(cyc - start);
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the IR codec with its receiver and LED partner.
`timescale 1ns/1ps
module tb_top;
  import irc_pkg::*;
  localparam int TICK = 4;
  localparam int CAR  = 9;
  logic                clk_i;
  logic                sys_rst_i;
  logic                ir_rx_n_i;
  logic                decoder_start_request_i;
  logic                decoder_stop_request_i;
  logic                transmit_request_i;
  logic [B_DEV_W-1:0]  tx_dev_i;
  logic [B_KEY_W-1:0]  tx_key_i;
  logic                decoder_active_o;
  logic [CODE_W-1:0]   dev_code_o;
  logic [CODE_W-1:0]   key_code_o;
  logic                key_event_o;
  logic                ir_tx_o;
  logic                tx_busy_o;
  int                  errors;
  int                  compares;
  int                  ev_cnt;
  int                  stray;

  irc_ir_codec #(.TICK_CYCLES(LEN_W'(TICK)), .CAR_HALF(LEN_W'(CAR))) irc_ir_codec_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ir_rx_n_i(ir_rx_n_i),
    .decoder_start_request_i(decoder_start_request_i), .decoder_stop_request_i(decoder_stop_request_i),
    .transmit_request_i(transmit_request_i), .tx_dev_i(tx_dev_i), .tx_key_i(tx_key_i),
    .decoder_active_o(decoder_active_o), .dev_code_o(dev_code_o), .key_code_o(key_code_o),
    .key_event_o(key_event_o), .ir_tx_o(ir_tx_o), .tx_busy_o(tx_busy_o));
  irc_ir_partner #(.TICK(TICK), .CAR(CAR)) irc_ir_partner_i (
    .clk_i(clk_i), .ir_tx_i(ir_tx_o), .ir_rx_n_o(ir_rx_n_i));

  always #25 clk_i = ~clk_i;

  // Counting high cycles, not edges, so a stretched event pulse shows as an extra event.
  always @(posedge clk_i) begin
    if (key_event_o === 1'b1) ev_cnt++;
    if (ir_tx_o === 1'b1 && tx_busy_o !== 1'b1) stray++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic lv(input logic v, input int t);
    irc_ir_partner_i.level(v, t);
  endtask

  task automatic ctrl(input logic go, input logic halt);
    step();
    decoder_start_request_i = go;
    decoder_stop_request_i = halt;
    step();
    decoder_start_request_i = 1'b0;
    decoder_stop_request_i = 1'b0;
    step();
  endtask

  task automatic expect_rx(input int ev0, input int nev, input logic [7:0] dev, input logic [7:0] key);
    check(16'(ev_cnt - ev0), 16'(nev), "event count");
    check({8'h00, dev_code_o}, {8'h00, dev}, "device code");
    check({8'h00, key_code_o}, {8'h00, key}, "key code");
  endtask

  task automatic send_a(input logic [7:0] dev, input logic [7:0] key);
    logic [31:0] w;
    w = {~key, key, ~dev, dev};
    lv(1'b0, 900);
    lv(1'b1, 450);
    for (int i = 0; i < 32; i++) begin
      lv(1'b0, 56);
      lv(1'b1, w[i] ? 168 : 56);
    end
    lv(1'b0, 56);
    lv(1'b1, 50);
  endtask

  task automatic send_b(input int lead, input logic [4:0] dev, input logic [6:0] key);
    logic [11:0] w;
    w = {dev, key};
    lv(1'b0, lead);
    for (int i = 0; i < 12; i++) begin
      lv(1'b1, 60);
      lv(1'b0, w[i] ? 120 : 60);
    end
    lv(1'b1, 50);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start();
    check({dev_code_o, key_code_o}, 16'h0000, "codes after reset");
    check({12'h000, decoder_active_o, key_event_o, ir_tx_o, tx_busy_o}, 16'h0000, "flags after reset");
    ctrl(1'b1, 1'b0);
    check({15'h0000, decoder_active_o}, 16'h0001, "decoder on");
  endtask

  task automatic t_proto_a();
    int e;
    e = ev_cnt;
    send_a(8'h01, 8'h12);
    expect_rx(e, 1, 8'h80, 8'h48);
  endtask

  task automatic t_repeat();
    int e;
    e = ev_cnt;
    lv(1'b0, 900);
    lv(1'b1, 225);
    lv(1'b0, 56);
    lv(1'b1, 50);
    expect_rx(e, 1, 8'h80, 8'h48);
  endtask

  task automatic t_proto_b();
    int e;
    e = ev_cnt;
    send_b(240, 5'h16, 7'h4b);
    expect_rx(e, 1, 8'h16, 8'h4b);
    send_b(240, 5'h01, 7'h7f);
    expect_rx(e, 2, 8'h01, 8'h7f);
  endtask

  task automatic t_bad();
    int e;
    e = ev_cnt;
    send_b(150, 5'h0c, 7'h33);
    lv(1'b0, 240);
    lv(1'b1, 1250);
    expect_rx(e, 0, 8'h01, 8'h7f);
  endtask

  task automatic t_stop();
    int e;
    ctrl(1'b1, 1'b1);
    check({15'h0000, decoder_active_o}, 16'h0000, "decoder off");
    e = ev_cnt;
    send_b(240, 5'h1f, 7'h00);
    expect_rx(e, 0, 8'h01, 8'h7f);
  endtask

  task automatic t_tx();
    int          c;
    logic [11:0] got;
    check(16'(stray), 16'h0000, "led lit while idle");
    step();
    tx_dev_i = 5'h13;
    tx_key_i = 7'h2d;
    transmit_request_i = 1'b1;
    step();
    check({14'h0000, tx_busy_o, ir_tx_o}, 16'h0003, "start of send");
    tx_dev_i = 5'h0a;
    tx_key_i = 7'h52;
    c = 1;
    repeat (3) begin
      step();
      c++;
    end
    transmit_request_i = 1'b0;
    while (tx_busy_o === 1'b1 && c < 12000) begin
      step();
      c++;
    end
    check({15'h0000, c >= 9995 && c <= 10005}, 16'h0001, "send duration");
    check(16'(irc_ir_partner_i.first_hi), 16'(CAR), "carrier half period");
    check(16'(irc_ir_partner_i.widths.size()), 16'd13, "mark count");
    check({15'h0000, irc_ir_partner_i.widths[0] > 700}, 16'h0001, "leader mark");
    for (int i = 0; i < 12; i++) got[i] = irc_ir_partner_i.widths[i + 1] > 370;
    check({4'h0, got}, {4'h0, 5'h13, 7'h2d}, "sent payload");
    repeat (20) step();
    check({15'h0000, ir_tx_o}, 16'h0000, "idle after send");
    check(16'(stray), 16'h0000, "led lit while idle");
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    decoder_start_request_i = 1'b0;
    decoder_stop_request_i = 1'b0;
    transmit_request_i = 1'b0;
    tx_dev_i = 5'h00;
    tx_key_i = 7'h00;
    repeat (4) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_start();
    t_proto_a();
    t_repeat();
    t_proto_b();
    t_bad();
    t_stop();
    t_tx();
    stop_test();
  end

  // The tests need about 82000 cycles; the margin covers a hang in any single wait.
  initial begin
    repeat (99000) @(posedge clk_i);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
